// [verilog/adcc_ctrl.sv]
// Converter control register, sample/convert sequencing and result formatting
//
// How it works
// - Enable bit 15 runs or stops converter
// - Stop-in-idle bit 13 halts on idle
// - Codes 101/100/000 give integer result forms
// - Codes 111/110 left-justify into 32 bits
// - Codes 011/010 left-justify into low 16
// - Code 111 uses internal counter; 4-6 reserved
// - Code 010 uses timer three match
// - Code 001 uses external pin edge
// - Code 011 uses charge time unit
// - Code 000: software clear starts conversion
// - Software writes one to start sampling
// - Auto start sets sampling by hardware
// - Codes 001/010/011/111: hardware ends sampling
// - Conversion end sets complete flag
// - Writing zero clears complete flag; one is ignored
// - Conversion start clears complete flag
// - Unimplemented control bits read zero
//
// The placing of the registers and the APB register port were left to the implementer.
module adcc_ctrl
   import adcc_pkg::*;
#(
   parameter int SAMPLE_CYCLES = ADCC_SAMPLE_CYCLES
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Device and trigger sources
   input  wire logic        dev_idle,
   input  wire logic        timer3_match,
   input  wire logic        ext_interrupt_zero_pin,
   input  wire logic        charge_time_unit,
   // Analog core
   input  wire logic [9:0]  core_result,
   input  wire logic        core_done,
   output logic             sample_en,
   output logic             conv_start,
   output logic             module_active,
   output logic      [31:0] result_out
);

   logic [1:0]  rst_sync_r;     // Reset release synchroniser
   logic        rst_n;          // Synchronised reset
   adcc_ctrl_t  ctrl_r;         // Control fields
   logic        sample_r;       // Sampling in progress
   logic        done_r;         // Conversion complete flag
   logic        busy_r;         // Conversion in progress
   logic [2:0]  pin_sync_r;     // Pin synchroniser plus edge history
   logic [15:0] sample_active_cnt_r;     // Auto-convert sample counter
   logic [9:0]  raw_r;          // Last raw result
   logic        wr_ctrl;        // Control write strobe
   logic        active;         // Converter allowed to run
   logic        trig;           // Selected trigger event
   logic        end_sample_active;       // Sampling ends, conversion starts
   logic [31:0] fmt_nxt;        // Formatted result

   // Reset released through two flops; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) rst_sync_r <= 2'h0;
      else        rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   // Zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_ctrl = psel & penable & pwrite & (paddr == ADCC_CTRL_OFF);

   always_comb begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == ADCC_CTRL_OFF) begin
         prdata[ADCC_ON_BIT]                    = ctrl_r.on;
         prdata[ADCC_IDLE_BIT]                  = ctrl_r.stop_in_idle;
         prdata[ADCC_FORM_LSB+:3]               = ctrl_r.output_format_sel;
         prdata[ADCC_TRIG_LSB+:3]               = ctrl_r.trigger_source_sel;
         prdata[ADCC_CLRAS_BIT]                 = ctrl_r.auto_sample_clear;
         prdata[ADCC_ASTART_BIT]                = ctrl_r.auto_sample_start;
         prdata[ADCC_SAMPLE_BIT]                = sample_r;
         prdata[ADCC_DONE_BIT]                  = done_r;
      end else if (paddr == ADCC_RESULT_OFF) begin
         prdata = result_out;
      end else begin
         // Unmapped address answers with an error
         pslverr = psel & penable;
      end
   end

   assign active        = ctrl_r.on & ~(ctrl_r.stop_in_idle & dev_idle);
   assign module_active = active;

   // Plain control fields; auto start also dropped by hardware after a conversion when auto clear is set
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r.on                 <= pwdata[ADCC_ON_BIT];
            ctrl_r.stop_in_idle       <= pwdata[ADCC_IDLE_BIT];
            ctrl_r.output_format_sel  <= adcc_fmt_t'(pwdata[ADCC_FORM_LSB+:3]);
            ctrl_r.trigger_source_sel <= adcc_trg_t'(pwdata[ADCC_TRIG_LSB+:3]);
            ctrl_r.auto_sample_clear  <= pwdata[ADCC_CLRAS_BIT];
            ctrl_r.auto_sample_start  <= pwdata[ADCC_ASTART_BIT];
         end
         if (core_done & busy_r & ctrl_r.auto_sample_clear) begin
            ctrl_r.auto_sample_start <= 1'b0;
         end
      end
   end

   // External pin: two flops, then a third for rising-edge detection
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) pin_sync_r <= 3'h0;
      else        pin_sync_r <= {pin_sync_r[1:0], ext_interrupt_zero_pin};
   end

   // Sample counter restarts whenever sampling is not running
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)         sample_active_cnt_r <= 16'h0000;
      else if (!sample_r) sample_active_cnt_r <= 16'h0000;
      else if (!end_sample_active) sample_active_cnt_r <= sample_active_cnt_r + 16'h0001;
   end

   // Trigger selection; reserved codes never fire
   always_comb begin
      case (ctrl_r.trigger_source_sel)
         ADCC_TRG_EXTPIN: trig = pin_sync_r[1] & ~pin_sync_r[2];
         ADCC_TRG_TIMER3: trig = timer3_match;
         ADCC_TRG_CHARGE: trig = charge_time_unit;
         ADCC_TRG_AUTO:   trig = (sample_active_cnt_r == 16'(SAMPLE_CYCLES - 1));
         default:         trig = 1'b0;
      endcase
   end

   assign end_sample_active = active & sample_r &
      ((ctrl_r.trigger_source_sel == ADCC_TRG_MANUAL) ?
         (wr_ctrl & ~pwdata[ADCC_SAMPLE_BIT]) : trig);
   assign conv_start = end_sample_active;
   assign sample_en  = sample_r;

   // Sampling flag: cleared when stopped so a disable never leaves it hanging
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_r <= ADCC_FIELD_RST;
      end else if (!active) begin
         sample_r <= 1'b0;
      end else if (end_sample_active) begin
         sample_r <= 1'b0;
      end else if (ctrl_r.auto_sample_start & ~busy_r) begin
         sample_r <= 1'b1;
      end else if (wr_ctrl & pwdata[ADCC_SAMPLE_BIT] & ~ctrl_r.auto_sample_start) begin
         sample_r <= 1'b1;
      end
   end

   // Conversion busy from start until the core reports the end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)        busy_r <= 1'b0;
      else if (!active)  busy_r <= 1'b0;
      else if (end_sample_active) busy_r <= 1'b1;
      else if (core_done) busy_r <= 1'b0;
   end

   // Complete flag: set beats a software clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= ADCC_FIELD_RST;
      end else if (core_done & busy_r) begin
         done_r <= 1'b1;
      end else if (end_sample_active) begin
         done_r <= 1'b0;
      end else if (wr_ctrl & ~pwdata[ADCC_DONE_BIT]) begin
         done_r <= 1'b0;
      end
   end

   // Capture raw result at the end of a conversion
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)                  raw_r <= 10'h000;
      else if (core_done & busy_r) raw_r <= core_result;
   end

   // Result formatting; the reserved code falls back to plain 16-bit integer
   always_comb begin
      case (ctrl_r.output_format_sel)
         ADCC_FMT_SFR32, ADCC_FMT_FRAC32: fmt_nxt = {raw_r, 22'h000000};
         ADCC_FMT_SINT32: fmt_nxt = {{22{raw_r[9]}}, raw_r};
         ADCC_FMT_SFR16, ADCC_FMT_FRAC16: fmt_nxt = {16'h0000, raw_r, 6'h00};
         default:         fmt_nxt = {22'h000000, raw_r};
      endcase
   end

   // Result output held in a flop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) result_out <= 32'h0000_0000;
      else        result_out <= fmt_nxt;
   end

   // Checks on the sequencing, result formats and unused register bits
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_conv_begins;
      end_sample_active ##1 (busy_r && !sample_r);
   endsequence

   a_trig_ends_sample: assert property (
      (active && sample_r && ctrl_r.trigger_source_sel == ADCC_TRG_TIMER3 && timer3_match)
      |-> s_conv_begins)
      else $error("timer trigger did not start conversion");
   a_off_stops_all: assert property (
      !ctrl_r.on |=> !sample_r && !busy_r)
      else $error("converter kept running while disabled");
   a_idle_stop: assert property (
      (ctrl_r.stop_in_idle && dev_idle) |-> !module_active ##1 !sample_r)
      else $error("converter ran during idle");
   a_done_sets: assert property (
      (core_done && busy_r) |=> done_r && !busy_r)
      else $error("complete flag not set");
   a_start_clr_done: assert property (
      (end_sample_active && !(core_done && busy_r)) |=> !done_r)
      else $error("complete flag not cleared at start");
   a_write_one_keep: assert property (
      (done_r && wr_ctrl && pwdata[ADCC_DONE_BIT] && !end_sample_active) |=> done_r)
      else $error("writing one cleared the flag");
   a_auto_start: assert property (
      (active && ctrl_r.auto_sample_start && !busy_r && !sample_r) |=> sample_r)
      else $error("auto start did not begin sampling");
   a_auto_count: assert property (
      (active && sample_r && ctrl_r.trigger_source_sel == ADCC_TRG_AUTO
       && sample_active_cnt_r == 16'(SAMPLE_CYCLES - 1)) |-> end_sample_active)
      else $error("internal counter did not end sampling");
   a_fmt_signed: assert property (
      (ctrl_r.output_format_sel == ADCC_FMT_SINT32 && $stable(raw_r)
       && $stable(ctrl_r.output_format_sel))
      |-> result_out == {{22{raw_r[9]}}, raw_r})
      else $error("signed integer format wrong");
   a_fmt_frac16: assert property (
      (ctrl_r.output_format_sel == ADCC_FMT_FRAC16 && $stable(raw_r)
       && $stable(ctrl_r.output_format_sel)) |=> result_out[31:16] == 16'h0000)
      else $error("16-bit fraction upper half not zero");
   a_unused_zero: assert property (
      (paddr == ADCC_CTRL_OFF) |-> (prdata[31:16] == 16'h0000 && prdata[14] == 1'b0
       && prdata[12:11] == 2'h0 && prdata[3] == 1'b0))
      else $error("unimplemented bits not zero");
   a_auto_clear: assert property (
      (core_done && busy_r && ctrl_r.auto_sample_clear && !wr_ctrl)
      |=> !ctrl_r.auto_sample_start)
      else $error("auto clear did not stop auto start");
endmodule

// [verilog/adcc_pkg.sv]
// Shared constants, codes and carrier types for the converter control block
package adcc_pkg;
   // Register byte offsets
   localparam logic [7:0] ADCC_CTRL_OFF   = 8'h00;
   localparam logic [7:0] ADCC_RESULT_OFF = 8'h04;
   // Control register field positions
   localparam int ADCC_ON_BIT    = 15;
   localparam int ADCC_IDLE_BIT   = 13;
   localparam int ADCC_FORM_LSB   = 8;
   localparam int ADCC_TRIG_LSB   = 5;
   localparam int ADCC_CLRAS_BIT  = 4;
   localparam int ADCC_ASTART_BIT = 2;
   localparam int ADCC_SAMPLE_BIT = 1;
   localparam int ADCC_DONE_BIT  = 0;
   // Reset value of every control field
   localparam logic ADCC_FIELD_RST = 1'b0;
   // Auto-convert sample length in cycles
   localparam int ADCC_SAMPLE_CYCLES = 16;
   // Output format codes
   typedef enum logic [2:0] {
      ADCC_FMT_INT16  = 3'h0,
      ADCC_FMT_RSVD   = 3'h1,
      ADCC_FMT_FRAC16 = 3'h2,
      ADCC_FMT_SFR16  = 3'h3,
      ADCC_FMT_INT32  = 3'h4,
      ADCC_FMT_SINT32 = 3'h5,
      ADCC_FMT_FRAC32 = 3'h6,
      ADCC_FMT_SFR32  = 3'h7
   } adcc_fmt_t;
   // Trigger source codes
   typedef enum logic [2:0] {
      ADCC_TRG_MANUAL = 3'h0,
      ADCC_TRG_EXTPIN = 3'h1,
      ADCC_TRG_TIMER3 = 3'h2,
      ADCC_TRG_CHARGE = 3'h3,
      ADCC_TRG_RSV4   = 3'h4,
      ADCC_TRG_RSV5   = 3'h5,
      ADCC_TRG_RSV6   = 3'h6,
      ADCC_TRG_AUTO   = 3'h7
   } adcc_trg_t;
   // Software-visible control fields
   typedef struct packed {
      logic      on;
      logic      stop_in_idle;
      adcc_fmt_t output_format_sel;
      adcc_trg_t trigger_source_sel;
      logic      auto_sample_clear;
      logic      auto_sample_start;
   } adcc_ctrl_t;
endpackage

// [sim/adcc_core_model.sv]
// Behavioural sample-and-convert core that answers conversion starts
module adcc_core_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Control from the converter block
   input  wire logic       conv_start,
   input  wire logic [7:0] lat,
   input  wire logic [9:0] next_result,
   // Conversion answer
   output logic            core_done,
   output logic      [9:0] core_result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_r;  // Cycles left in the running conversion
   // Count a conversion down; a zero latency still takes one cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r       <= 8'h00;
         core_done   <= 1'b0;
         core_result <= 10'h000;
      end else begin
         core_done   <= 1'b0;
         // Junk off the done cycle, so a stale result is never reused
         core_result <= ~core_result;
         if (conv_start) begin
            cnt_r <= (lat == 8'h00) ? 8'h01 : lat;
         end else if (cnt_r == 8'h01) begin
            cnt_r       <= 8'h00;
            core_done   <= 1'b1;
            core_result <= next_result;
         end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule

// [sim/testbench.sv]
// Self-checking bench: converter control block against a core model
module testbench
   import adcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Drive and observe signals
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, dev_idle;
   logic timer3_match, ext_pin, charge, conv_start, sample_en, module_active, core_done;
   logic [7:0]  paddr, lat;
   logic [31:0] pwdata, prdata, result_out;
   logic [9:0]  core_result, next_res;
   logic [32:0] exp_q[$];  // Expected read data, error flag on top
   logic [32:0] e;
   logic [2:0]  tcode[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   int miscompares = 0, comparisons = 0, n_conv = 0, n_done = 0, seed = 20, i, bc, bd;
   adcc_ctrl #(.SAMPLE_CYCLES(4)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dev_idle(dev_idle), .timer3_match(timer3_match),
      .ext_interrupt_zero_pin(ext_pin), .charge_time_unit(charge),
      .core_result(core_result), .core_done(core_done), .sample_en(sample_en),
      .conv_start(conv_start), .module_active(module_active), .result_out(result_out));
   adcc_core_model u_core (.sys_clk(sys_clk), .rst_b(rst_b), .conv_start(conv_start),
      .lat(lat), .next_result(next_res), .core_done(core_done), .core_result(core_result));
   // Compare and count
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task complete_run;
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // APB transfer: setup, access, hold until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Reads leave their expectation for the monitor
   task rd(input logic [7:0] a, input logic [31:0] x, input logic er);
      exp_q.push_back({er, x});
      apb(1'b0, a, 32'h0);
   endtask
   // Bounded wait for an event counter to move past its base
   task automatic wait_ev(ref int cnt, input int b);
      for (int k = 0; k < 300 && cnt == b; k++) @(negedge sys_clk);
      check(cnt > b, 1'b1);
   endtask
   // Reference result layout per output format code
   function automatic logic [31:0] fmt(input logic [2:0] f, input logic [9:0] r);
      case (f)
         3'h5: return {{22{r[9]}}, r};
         3'h6, 3'h7: return {r, 22'h0};
         3'h2, 3'h3: return {16'h0, r, 6'h0};
         default: return {22'h0, r};
      endcase
   endfunction
   // Produce the end-of-sampling event for one trigger code
   task fire(input logic [2:0] t, input logic [31:0] c);
      @(posedge sys_clk);
      if (t == 3'h0) wr(ADCC_CTRL_OFF, c);
      ext_pin <= (t == 3'h1);
      timer3_match <= (t == 3'h2);
      charge <= (t == 3'h3);
      // Pin held a while so the synchroniser sees the rising edge
      @(posedge sys_clk);
      timer3_match <= 1'b0;
      charge <= 1'b0;
      repeat (3) @(posedge sys_clk);
      ext_pin <= 1'b0;
   endtask
   // One full conversion; written done=1 is ignored so the flag survives
   task automatic convert(input logic [2:0] f, input logic [2:0] t);
      logic [31:0] c;
      c = 32'h8001 | (32'(f) << 8) | (32'(t) << 5);
      next_res <= 10'($random(seed));
      wr(ADCC_CTRL_OFF, c);
      wr(ADCC_CTRL_OFF, c | 32'h2);
      @(posedge sys_clk);
      @(negedge sys_clk);
      bc = n_conv;
      bd = n_done;
      if (t != 3'h7) check(sample_en, 1'b1);
      fire(t, c);
      wait_ev(n_conv, bc);
      rd(ADCC_CTRL_OFF, c & ~32'h1, 1'b0);
      wait_ev(n_done, bd);
      repeat (3) @(posedge sys_clk);
      rd(ADCC_CTRL_OFF, c, 1'b0);
      rd(ADCC_RESULT_OFF, fmt(f, next_res), 1'b0);
   endtask
   // Read monitor takes the oldest expectation at each completed read
   always @(posedge sys_clk) begin
      if (psel && penable && pready && !pwrite) begin
         e = exp_q.pop_front();
         check(prdata, e[31:0]);
         check({31'h0, pslverr}, {31'h0, e[32]});
      end
   end
   // Event counters for conversion starts and completions
   always @(negedge sys_clk) begin
      if (conv_start === 1'b1) n_conv++;
      if (core_done === 1'b1) n_done++;
   end
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      complete_run();
   end
   // Main sequence
   initial begin
      {rst_b, psel, penable, pwrite, dev_idle, timer3_match, ext_pin, charge} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      lat = 8'h1E;
      next_res = 10'h000;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(ADCC_CTRL_OFF, 32'h0, 1'b0);
      wr(ADCC_CTRL_OFF, 32'hFFFF7FFD);
      rd(ADCC_CTRL_OFF, 32'h27F4, 1'b0);
      for (i = 0; i < 8; i++) begin
         if (i != 1) convert(3'(i), tcode[i % 5]);
      end
      lat <= 8'h01;
      next_res <= 10'($random(seed));
      bc = n_conv;
      bd = n_done;
      wr(ADCC_CTRL_OFF, 32'h84F4);
      @(posedge sys_clk);
      @(negedge sys_clk);
      check(sample_en, 1'b1);
      wait_ev(n_conv, bc);
      wait_ev(n_done, bd);
      repeat (3) @(posedge sys_clk);
      rd(ADCC_CTRL_OFF, 32'h84F1, 1'b0);
      wr(ADCC_RESULT_OFF, 32'hFFFFFFFF);
      rd(ADCC_RESULT_OFF, fmt(3'h4, next_res), 1'b0);
      for (i = 4; i < 7; i++) begin
         wr(ADCC_CTRL_OFF, 32'h8003 | (i << 5));
         bc = n_conv;
         fire(3'h2, 32'h0);
         fire(3'h3, 32'h0);
         check(n_conv - bc, 32'h0);
         check(sample_en, 1'b1);
      end
      wr(ADCC_CTRL_OFF, 32'h1);
      // Look once the write has landed, not in its own edge
      @(negedge sys_clk);
      check(module_active, 1'b0);
      @(posedge sys_clk);
      rd(ADCC_CTRL_OFF, 32'h1, 1'b0);
      wr(ADCC_CTRL_OFF, 32'h8001);
      rd(ADCC_CTRL_OFF, 32'h8001, 1'b0);
      wr(ADCC_CTRL_OFF, 32'h8000);
      rd(ADCC_CTRL_OFF, 32'h8000, 1'b0);
      wr(ADCC_CTRL_OFF, 32'hA002);
      dev_idle <= 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      check({module_active, sample_en}, 2'h0);
      // Clearing stop-in-idle first: a start written while halted is refused
      wr(ADCC_CTRL_OFF, 32'h8000);
      wr(ADCC_CTRL_OFF, 32'h8002);
      @(negedge sys_clk);
      check({module_active, sample_en}, 2'h3);
      dev_idle <= 1'b0;
      wr(8'h08, 32'hFFFFFFFF);
      rd(8'h08, 32'h0, 1'b1);
      complete_run();
   end
endmodule
